// >>> hdl/pcgc_ctrl.sv
// PLL programming, bus clock selection and clock gating controller.
// Assumes an APB master on clk, a slow-rate enable pulse and clock enables.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "pcgc_cfg.svh"
module pcgc_ctrl (
	// System
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Events
	input wire logic slowTick,
	input wire logic coreIrq,
	input wire logic instrDone,
	input wire logic usbSuspend,
	// Clock controls
	output logic [7:0] pllAInDiv,
	output logic [10:0] pllAMult,
	output logic pllAEnable,
	output logic [7:0] pllBInDiv,
	output logic [10:0] pllBMult,
	output logic pllBEnable,
	output logic pllBHalve,
	output logic [1:0] busSrc,
	output logic [2:0] busPres,
	output logic [1:0] coreRatio,
	output logic coreClkEn,
	output logic [31:0] periphClkEn,
	output logic usbFuncClkEn,
	output logic usbFuncBusClkEn,
	output logic usbHostClkEn,
	output logic [7:0] outClkCfg [0:3],
	output logic [3:0] outClkEn
);
	import pcgc_pkg::*;
	pcgc_pll_t pllA;
	pcgc_pll_t pllB;
	pcgc_busclk_t busCfg;
	pcgc_outclk_t outCfg [0:3];
	logic [5:0] lockCntA;
	logic [5:0] lockCntB;
	logic pll_a_locked_flag;
	logic pll_b_locked_flag;
	logic busRdy;
	logic [3:0] outRdy;
	logic stopPending;
	logic autoOff;
	logic slowSync1;
	logic slowSync2;
	logic slowSync3;
	logic slowEdge;
	pcgc_sw_t swState;
	logic [7:0] swCnt;
	logic wrEn;
	logic [31:0] next_rdata;
	logic [31:0] scState;
	logic [31:0] stat;
	pcgc_pll_t wrPll;

	assign wrEn = psel & penable & pwrite;
	assign wrPll = pcgc_pll_t'(pwdata);
	// Slow tick is taken through two flops before edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			slowSync1 <= 1'b0;
			slowSync2 <= 1'b0;
			slowSync3 <= 1'b0;
		end else begin
			slowSync1 <= slowTick;
			slowSync2 <= slowSync1;
			slowSync3 <= slowSync2;
		end
	end
	assign slowEdge = slowSync2 & ~slowSync3;

	// PLL A registers and lock logic
	always_ff @(posedge clk) begin
		if (rst) begin
			pllA <= pcgc_pll_t'(`PCGC_PLL_RESET);
			pll_a_locked_flag <= 1'b0;
			lockCntA <= '0;
		end else if (wrEn && paddr == `PCGC_OFF_PLLA) begin
			pllA <= wrPll;
			pllA.halve <= 1'b0;
			pll_a_locked_flag <= 1'b0;
			lockCntA <= wrPll.lockCount;
		end else if (slowEdge && pllA.mult != '0 && !pll_a_locked_flag) begin
			if (lockCntA == '0)
				pll_a_locked_flag <= 1'b1;
			else
				lockCntA <= lockCntA - 6'd1;
		end
	end

	// PLL B registers and lock logic
	always_ff @(posedge clk) begin
		if (rst) begin
			pllB <= pcgc_pll_t'(`PCGC_PLL_RESET);
			pll_b_locked_flag <= 1'b0;
			lockCntB <= '0;
		end else if (wrEn && paddr == `PCGC_OFF_PLLB) begin
			pllB <= wrPll;
			pll_b_locked_flag <= 1'b0;
			lockCntB <= wrPll.lockCount;
		end else if (slowEdge && pllB.mult != '0 && !pll_b_locked_flag) begin
			if (lockCntB == '0)
				pll_b_locked_flag <= 1'b1;
			else
				lockCntB <= lockCntB - 6'd1;
		end
	end

	// PLL control outputs registered
	always_ff @(posedge clk) begin
		if (rst) begin
			pllAInDiv <= '0;
			pllAMult <= '0;
			pllAEnable <= 1'b0;
			pllBInDiv <= '0;
			pllBMult <= '0;
			pllBEnable <= 1'b0;
			pllBHalve <= 1'b0;
		end else begin
			pllAInDiv <= pllA.inDiv;
			pllAMult <= pllA.mult;
			pllAEnable <= (pllA.mult != '0) && (pllA.inDiv != '0);
			pllBInDiv <= pllB.inDiv;
			pllBMult <= pllB.mult;
			pllBEnable <= (pllB.mult != '0) && (pllB.inDiv != '0);
			pllBHalve <= pllB.halve;
		end
	end

	// Bus clock config and switch sequencer; output held during settle
	always_ff @(posedge clk) begin
		if (rst) begin
			busCfg <= '0;
			busRdy <= 1'b1;
			swState <= PCGC_SW_IDLE;
			swCnt <= '0;
			busSrc <= `PCGC_SEL_SLOW;
			busPres <= '0;
			coreRatio <= '0;
		end else if (wrEn && paddr == `PCGC_OFF_BUSCLK) begin
			busCfg <= pcgc_busclk_t'(pwdata);
			busRdy <= 1'b0;
			swState <= PCGC_SW_SETTLE;
			swCnt <= `PCGC_SYNC_SETTLE;
		end else begin
			case (swState)
				PCGC_SW_IDLE: swCnt <= '0;
				PCGC_SW_SETTLE: begin
					if (swCnt == '0) begin
						busSrc <= busCfg.src;
						busPres <= (busCfg.power_of_two_divider_field > `PCGC_POWER_OF_TWO_DIVIDER_FIELD_MAX) ? `PCGC_POWER_OF_TWO_DIVIDER_FIELD_MAX
							: busCfg.power_of_two_divider_field;
						coreRatio <= busCfg.ratio;
						if (busCfg.power_of_two_divider_field != '0) begin
							swState <= PCGC_SW_PRESC;
							swCnt <= `PCGC_POWER_OF_TWO_DIVIDER_FIELD_EXTRA;
						end else begin
							swState <= PCGC_SW_IDLE;
							busRdy <= 1'b1;
						end
					end else if (slowEdge) begin
						swCnt <= swCnt - 8'd1;
					end
				end
				PCGC_SW_PRESC: begin
					if (swCnt == '0) begin
						swState <= PCGC_SW_IDLE;
						busRdy <= 1'b1;
					end else begin
						swCnt <= swCnt - 8'd1;
					end
				end
				default: swState <= PCGC_SW_IDLE;
			endcase
		end
	end

	// Core clock gate; wake wins over a stop request
	always_ff @(posedge clk) begin
		if (rst) begin
			coreClkEn <= 1'b1;
			stopPending <= 1'b0;
		end else if (coreIrq) begin
			coreClkEn <= 1'b1;
			stopPending <= 1'b0;
		end else if (wrEn && paddr == `PCGC_OFF_SCCLR && pwdata[`PCGC_SC_CORE]) begin
			stopPending <= 1'b1;
		end else if (wrEn && paddr == `PCGC_OFF_SCSET && pwdata[`PCGC_SC_CORE]) begin
			coreClkEn <= 1'b1;
			stopPending <= 1'b0;
		end else if (stopPending && instrDone) begin
			coreClkEn <= 1'b0;
			stopPending <= 1'b0;
		end
	end

	// USB function, host and auto-off bits; suspend overrides the USB function enable
	always_ff @(posedge clk) begin
		if (rst) begin
			usbFuncClkEn <= 1'b0;
			usbHostClkEn <= 1'b0;
			autoOff <= 1'b0;
			usbFuncBusClkEn <= 1'b1;
		end else begin
			if (usbSuspend) begin
				usbFuncClkEn <= 1'b0;
				if (autoOff)
					usbFuncBusClkEn <= 1'b0;
			end else if (wrEn && paddr == `PCGC_OFF_SCSET && pwdata[`PCGC_SC_USBF]) begin
				usbFuncClkEn <= 1'b1;
				usbFuncBusClkEn <= 1'b1;
			end else if (wrEn && paddr == `PCGC_OFF_SCCLR && pwdata[`PCGC_SC_USBF]) begin
				usbFuncClkEn <= 1'b0;
			end
			if (wrEn && paddr == `PCGC_OFF_SCSET && pwdata[`PCGC_SC_USBH])
				usbHostClkEn <= 1'b1;
			else if (wrEn && paddr == `PCGC_OFF_SCCLR && pwdata[`PCGC_SC_USBH])
				usbHostClkEn <= 1'b0;
			if (wrEn && paddr == `PCGC_OFF_SCSET && pwdata[`PCGC_SC_AUTOOFF])
				autoOff <= 1'b1;
			else if (wrEn && paddr == `PCGC_OFF_SCCLR && pwdata[`PCGC_SC_AUTOOFF])
				autoOff <= 1'b0;
		end
	end

	// Peripheral gates, one per identifier
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : gPeriph
			always_ff @(posedge clk) begin
				if (rst)
					periphClkEn[g] <= 1'b0;
				else if (wrEn && paddr == `PCGC_OFF_PCSET && pwdata[g])
					periphClkEn[g] <= 1'b1;
				else if (wrEn && paddr == `PCGC_OFF_PCCLR && pwdata[g])
					periphClkEn[g] <= 1'b0;
			end
		end
		// Output clocks; ready set one cycle after config lands
		for (g = 0; g < 4; g++) begin : gOut
			always_ff @(posedge clk) begin
				if (rst) begin
					outCfg[g] <= '0;
					outClkEn[g] <= 1'b0;
					outRdy[g] <= 1'b0;
					outClkCfg[g] <= '0;
				end else begin
					if (wrEn && paddr == `PCGC_OFF_OUTCLK + 8'(4 * g)) begin
						outCfg[g] <= pcgc_outclk_t'(pwdata);
						outRdy[g] <= 1'b0;
					end else begin
						outClkCfg[g] <= {3'h0, outCfg[g].power_of_two_divider_field, outCfg[g].src};
						outRdy[g] <= 1'b1;
					end
					if (wrEn && paddr == `PCGC_OFF_SCSET && pwdata[`PCGC_SC_OUT0 + g])
						outClkEn[g] <= 1'b1;
					else if (wrEn && paddr == `PCGC_OFF_SCCLR && pwdata[`PCGC_SC_OUT0 + g])
						outClkEn[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Read mux
	always_comb begin
		scState = '0;
		scState[`PCGC_SC_CORE] = coreClkEn;
		scState[`PCGC_SC_USBF] = usbFuncClkEn;
		scState[`PCGC_SC_AUTOOFF] = autoOff;
		scState[`PCGC_SC_USBH] = usbHostClkEn;
		scState[`PCGC_SC_OUT0 +: 4] = outClkEn;
		stat = '0;
		stat[`PCGC_ST_PLL_A_LOCKED_FLAG] = pll_a_locked_flag;
		stat[`PCGC_ST_PLL_B_LOCKED_FLAG] = pll_b_locked_flag;
		stat[`PCGC_ST_BUSRDY] = busRdy;
		stat[`PCGC_ST_OUTRDY0 +: 4] = outRdy;
		case (paddr)
			`PCGC_OFF_SCSTATE: next_rdata = scState;
			`PCGC_OFF_PCSTATE: next_rdata = periphClkEn;
			`PCGC_OFF_PLLA: next_rdata = pllA;
			`PCGC_OFF_PLLB: next_rdata = pllB;
			`PCGC_OFF_BUSCLK: next_rdata = busCfg;
			`PCGC_OFF_OUTCLK: next_rdata = outCfg[0];
			`PCGC_OFF_OUTCLK + 8'h04: next_rdata = outCfg[1];
			`PCGC_OFF_OUTCLK + 8'h08: next_rdata = outCfg[2];
			`PCGC_OFF_OUTCLK + 8'h0C: next_rdata = outCfg[3];
			`PCGC_OFF_STATUS: next_rdata = stat;
			default: next_rdata = '0;
		endcase
	end

	// APB answer: no wait states, data registered
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel & ~penable & ~pwrite)
				prdata <= next_rdata;
		end
	end
	a_lock_clear: assert property (@(posedge clk) disable iff (rst)
		wrEn && paddr == `PCGC_OFF_PLLA |=> !pll_a_locked_flag)
		else $error("lock A not cleared on write");
	a_ready_clear: assert property (@(posedge clk) disable iff (rst)
		wrEn && paddr == `PCGC_OFF_BUSCLK |=> !busRdy)
		else $error("bus ready not cleared");
	a_periph_set: assert property (@(posedge clk) disable iff (rst)
		wrEn && paddr == `PCGC_OFF_PCSET && pwdata[0] |=> periphClkEn[0])
		else $error("peripheral enable missed");
	a_core_wake: assert property (@(posedge clk) disable iff (rst)
		coreIrq |=> coreClkEn)
		else $error("core not woken");
	a_core_wait: assert property (@(posedge clk) disable iff (rst)
		coreClkEn && !instrDone && !coreIrq |=> coreClkEn)
		else $error("core stopped mid instruction");
	a_suspend_off: assert property (@(posedge clk) disable iff (rst)
		usbSuspend |=> !usbFuncClkEn)
		else $error("usb clock still on in suspend");
	a_lock_step: assert property (@(posedge clk) disable iff (rst)
		$rose(pll_a_locked_flag) |-> $past(lockCntA) == 6'd0)
		else $error("lock set before count done");
	a_power_of_two_divider_field_wait: assert property (@(posedge clk) disable iff (rst)
		swState == PCGC_SW_PRESC && !wrEn |-> !busRdy)
		else $error("ready during prescale wait");
endmodule : pcgc_ctrl
`default_nettype wire

// >>> hdl/pcgc_cfg.svh
// Constants for the PLL and clock gating controller.
// Assumes inclusion by bare name from the package and the design.
`ifndef PCGC_CFG_SVH
`define PCGC_CFG_SVH
`define PCGC_OFF_SCSET 8'h00
`define PCGC_OFF_SCCLR 8'h04
`define PCGC_OFF_SCSTATE 8'h08
`define PCGC_OFF_PCSET 8'h10
`define PCGC_OFF_PCCLR 8'h14
`define PCGC_OFF_PCSTATE 8'h18
`define PCGC_OFF_PLLA 8'h28
`define PCGC_OFF_PLLB 8'h2C
`define PCGC_OFF_BUSCLK 8'h30
`define PCGC_OFF_OUTCLK 8'h40
`define PCGC_OFF_STATUS 8'h68
`define PCGC_SC_CORE 0
`define PCGC_SC_USBF 1
`define PCGC_SC_AUTOOFF 2
`define PCGC_SC_USBH 4
`define PCGC_SC_OUT0 8
`define PCGC_ST_PLL_A_LOCKED_FLAG 1
`define PCGC_ST_PLL_B_LOCKED_FLAG 2
`define PCGC_ST_BUSRDY 3
`define PCGC_ST_OUTRDY0 8
`define PCGC_PLL_RESET 32'h0000_3F00
`define PCGC_SEL_SLOW 2'h0
`define PCGC_POWER_OF_TWO_DIVIDER_FIELD_MAX 3'h6
`define PCGC_POWER_OF_TWO_DIVIDER_FIELD_EXTRA 8'h40
`define PCGC_SYNC_SETTLE 8'h04
`endif

// >>> hdl/pcgc_pkg.sv
// Types for the PLL and clock gating controller.
// Assumes pcgc_cfg.svh is reachable on the include path.
`include "pcgc_cfg.svh"
package pcgc_pkg;
	typedef struct packed {
		logic [2:0] rsvd;
		logic halve;
		logic rsvd2;
		logic [10:0] mult;
		logic [1:0] rsvd3;
		logic [5:0] lockCount;
		logic [7:0] inDiv;
	} pcgc_pll_t;
	typedef struct packed {
		logic [21:0] rsvd;
		logic [1:0] ratio;
		logic [2:0] rsvd2;
		logic [2:0] power_of_two_divider_field;
		logic [1:0] src;
	} pcgc_busclk_t;
	typedef struct packed {
		logic [26:0] rsvd;
		logic [2:0] power_of_two_divider_field;
		logic [1:0] src;
	} pcgc_outclk_t;
	typedef enum logic [1:0] {
		PCGC_SW_IDLE = 2'b00,
		PCGC_SW_SETTLE = 2'b01,
		PCGC_SW_PRESC = 2'b10
	} pcgc_sw_t;
endpackage : pcgc_pkg

// >>> verification/pcgc_soft_model.sv
// Model of the software and clock sources around the clock controller.
// Assumes the bench steers it through three request levels on clk.
`timescale 1ns/10ps
`default_nettype none
module pcgc_soft_model #(
	parameter int SLOW_HALF = 4
) (
	// System
	input wire logic clk,
	input wire logic rst,
	// Scenario requests
	input wire logic holdInstr,
	input wire logic irqReq,
	input wire logic suspendReq,
	// Towards the controller
	output logic slowTick = 1'b0,
	output logic coreIrq = 1'b0,
	output logic instrDone = 1'b0,
	output logic usbSuspend = 1'b0
);
	int slowCnt = 0;
	// Slow clock never stops, reset or not
	always @(posedge clk) begin
		slowCnt <= (slowCnt == SLOW_HALF - 1) ? 0 : slowCnt + 1;
		if (slowCnt == SLOW_HALF - 1) slowTick <= !slowTick;
	end
	// Instructions end only every other cycle, never during a held one
	always @(posedge clk) begin
		instrDone <= !rst && !holdInstr && !instrDone;
		coreIrq <= irqReq;
		usbSuspend <= suspendReq;
	end
endmodule : pcgc_soft_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the clock controller over APB.
// Assumes the controller answers each access and the soft model drives events.
`timescale 1ns/10ps
`default_nettype none
`include "pcgc_cfg.svh"
module testbench;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, periphClkEn, rd;
	logic pready, pslverr, slowTick, coreIrq, instrDone, usbSuspend;
	logic holdInstr = 1'b0, irqReq = 1'b0, suspendReq = 1'b0;
	logic [7:0] pllAInDiv, pllBInDiv;
	logic [10:0] pllAMult, pllBMult;
	logic pllAEnable, pllBEnable, pllBHalve, coreClkEn;
	logic usbFuncClkEn, usbFuncBusClkEn, usbHostClkEn;
	logic [1:0] busSrc, coreRatio;
	logic [2:0] busPres;
	logic [7:0] outClkCfg [0:3];
	logic [3:0] outClkEn;
	int fail_count = 0, cmp_count = 0, cycles = 0, n;
	always #5 clk = !clk;
	pcgc_ctrl u_pcgc_ctrl (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slowTick(slowTick), .coreIrq(coreIrq),
		.instrDone(instrDone), .usbSuspend(usbSuspend), .pllAInDiv(pllAInDiv),
		.pllAMult(pllAMult), .pllAEnable(pllAEnable), .pllBInDiv(pllBInDiv),
		.pllBMult(pllBMult), .pllBEnable(pllBEnable), .pllBHalve(pllBHalve),
		.busSrc(busSrc), .busPres(busPres), .coreRatio(coreRatio),
		.coreClkEn(coreClkEn), .periphClkEn(periphClkEn), .usbFuncClkEn(usbFuncClkEn),
		.usbFuncBusClkEn(usbFuncBusClkEn), .usbHostClkEn(usbHostClkEn),
		.outClkCfg(outClkCfg), .outClkEn(outClkEn));
	pcgc_soft_model u_pcgc_soft_model (.clk(clk), .rst(rst), .holdInstr(holdInstr),
		.irqReq(irqReq), .suspendReq(suspendReq), .slowTick(slowTick),
		.coreIrq(coreIrq), .instrDone(instrDone), .usbSuspend(usbSuspend));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		chk("slave error", pslverr, 1'b0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic settle;
		repeat (3) @(posedge clk);
	endtask : settle
	task automatic pollStatus(input int bitNo);
		n = 0;
		do begin
			apb(1'b0, `PCGC_OFF_STATUS, 32'h0000_0000);
			n++;
		end while (rd[bitNo] !== 1'b1 && n < 60);
	endtask : pollStatus
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `PCGC_OFF_SCSTATE, 32'h0000_0000);
		chk("core on at reset", rd, 32'h0000_0001);
		apb(1'b0, `PCGC_OFF_PLLA, 32'h0000_0000);
		chk("pll reset", rd, `PCGC_PLL_RESET);
		chk("divider off", {pllAEnable, pllAInDiv}, 32'h0000_0000);
		apb(1'b0, `PCGC_OFF_BUSCLK, 32'h0000_0000);
		chk("bus source reset", {rd, busSrc}, {32'h0000_0000, `PCGC_SEL_SLOW});
		apb(1'b0, `PCGC_OFF_PCSTATE, 32'h0000_0000);
		chk("periph reset", {rd, periphClkEn}, 64'h0);
		apb(1'b1, `PCGC_OFF_PCSET, 32'h8000_0001);
		apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		// Peripheral 0 has no work pending when its clock is gated
		apb(1'b1, `PCGC_OFF_PCCLR, 32'h0000_0001);
		settle();
		apb(1'b0, `PCGC_OFF_PCSTATE, 32'h0000_0000);
		chk("periph gating", {rd, periphClkEn}, {2{32'h8000_0000}});
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("unmapped read", rd, 32'h0000_0000);
		// Lock count of 2, so lock sets on the third slow tick, then power down by zero multiplier
		apb(1'b1, `PCGC_OFF_PLLA, 32'h000A_0205);
		apb(1'b0, `PCGC_OFF_STATUS, 32'h0000_0000);
		chk("lock cleared", rd[`PCGC_ST_PLL_A_LOCKED_FLAG], 1'b0);
		chk("pll a drive", {pllAEnable, pllAMult, pllAInDiv}, {1'b1, 11'h00A, 8'h05});
		pollStatus(`PCGC_ST_PLL_A_LOCKED_FLAG);
		chk("lock set", rd[`PCGC_ST_PLL_A_LOCKED_FLAG], 1'b1);
		apb(1'b1, `PCGC_OFF_PLLA, 32'h0000_0205);
		settle();
		chk("pll a off", pllAEnable, 1'b0);
		apb(1'b0, `PCGC_OFF_STATUS, 32'h0000_0000);
		chk("lock dropped", rd[`PCGC_ST_PLL_A_LOCKED_FLAG], 1'b0);
		apb(1'b1, `PCGC_OFF_PLLB, 32'h13FF_01FF);
		settle();
		chk("pll b drive", {pllBHalve, pllBEnable, pllBMult, pllBInDiv},
			{2'b11, 11'h3FF, 8'hFF});
		// Software picks a value unlike the current one
		apb(1'b1, `PCGC_OFF_BUSCLK, 32'h0000_0106);
		apb(1'b0, `PCGC_OFF_STATUS, 32'h0000_0000);
		chk("ready cleared", {rd[`PCGC_ST_BUSRDY], busSrc}, 3'b000);
		pollStatus(`PCGC_ST_BUSRDY);
		chk("bus switched", {busSrc, busPres, coreRatio}, {2'h2, 3'h1, 2'h1});
		// Long instruction keeps the core running until it ends
		holdInstr <= 1'b1;
		apb(1'b1, `PCGC_OFF_SCCLR, 32'h0000_0001);
		settle();
		chk("core waits", coreClkEn, 1'b1);
		holdInstr <= 1'b0;
		settle();
		chk("core stopped", coreClkEn, 1'b0);
		irqReq <= 1'b1;
		settle();
		chk("core woken", coreClkEn, 1'b1);
		irqReq <= 1'b0;
		apb(1'b1, `PCGC_OFF_SCSET, 32'h0000_0016);
		settle();
		chk("usb on", {usbFuncClkEn, usbHostClkEn, usbFuncBusClkEn}, 3'b111);
		suspendReq <= 1'b1;
		settle();
		chk("suspend", {usbFuncClkEn, usbHostClkEn, usbFuncBusClkEn}, 3'b010);
		suspendReq <= 1'b0;
		// Outputs stay disabled while they are configured
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `PCGC_OFF_OUTCLK + 8'(4 * i), 32'((i << 2) | (3 - i)));
			settle();
			chk("output config", outClkCfg[i], 32'((i << 2) | (3 - i)));
		end
		apb(1'b1, `PCGC_OFF_SCSET, 32'h0000_0F00);
		settle();
		apb(1'b0, `PCGC_OFF_STATUS, 32'h0000_0000);
		chk("outputs on", {outClkEn, rd[11:8]}, 8'hFF);
		// Clear bits for core, host and outputs, then a reset in mid-run
		apb(1'b1, `PCGC_OFF_SCCLR, 32'h0000_0F11);
		settle();
		chk("cleared", {coreClkEn, usbHostClkEn, outClkEn}, 6'h00);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("reset wakes core", {coreClkEn, periphClkEn, outClkEn}, {1'b1, 36'h0});
		chk("reset gates periph", periphClkEn, 32'h0000_0000);
		apb(1'b0, `PCGC_OFF_BUSCLK, 32'h0000_0000);
		chk("reset bus source", {rd, busSrc}, {32'h0000_0000, `PCGC_SEL_SLOW});
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
